//--- tbio_pkg.sv
// shared constants for the three-bit digital port
package tbio_pkg;
   localparam int          VALUE_W       = 3;
   localparam logic [2:0]  VALUE_RESET   = 3'h0;
   localparam int          OUT0_BIT      = 0;
   localparam int          OUT1_BIT      = 1;
   localparam int          SHARED_BIT    = 2;
   localparam int          SYNC_STAGES   = 2;
endpackage

//--- tbio_sync.sv
// two-stage synchroniser for the shared pin input
`timescale 1ns/1ps
`default_nettype none
module tbio_sync
   import tbio_pkg::*;
(
   // clock and reset
   input  wire logic clock,
   input  wire logic arst_n,
   // data
   input  wire logic d,
   output logic      q
);
   logic meta_q;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= 1'h0;
         q      <= 1'h0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule
`default_nettype wire

//--- tbio_port.sv
// three-bit general-purpose digital port with one shared pin
`timescale 1ns/1ps
`default_nettype none
module tbio_port
   import tbio_pkg::*;
(
   // clock and reset
   input  wire logic               clock,
   input  wire logic               arst_n,
   // static configuration
   input  wire logic               digital_mode,
   // port value command and query
   input  wire logic               port_value_command,
   input  wire logic [VALUE_W-1:0] port_value_wdata,
   input  wire logic               port_value_query,
   output logic      [VALUE_W-1:0] port_value_rdata,
   output logic                    port_value_rvalid,
   // pins
   output logic                    pin1_out,
   output logic                    pin2_out,
   input  wire logic               pin3_in,
   output logic                    pin3_out,
   output logic                    pin3_oe
);
   logic [VALUE_W-1:0] value_q;
   logic               pin3_sync;

   tbio_sync u_sync (
      .clock  (clock),
      .arst_n (arst_n),
      .d      (pin3_in),
      .q      (pin3_sync)
   );

   // stored port value
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         value_q <= VALUE_RESET;
      end else if (port_value_command && digital_mode) begin
         value_q <= port_value_wdata;
      end
   end

   // fixed pins and shared pin direction follow the stored value; pin3_out is held low
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pin1_out <= 1'h0;
         pin2_out <= 1'h0;
         pin3_out <= 1'h0;
         pin3_oe  <= 1'h1;
      end else begin
         pin1_out <= value_q[OUT0_BIT];
         pin2_out <= value_q[OUT1_BIT];
         pin3_out <= 1'h0;
         pin3_oe  <= ~value_q[SHARED_BIT];
      end
   end

   // query answer
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         port_value_rdata  <= VALUE_RESET;
         port_value_rvalid <= 1'h0;
      end else begin
         port_value_rvalid <= port_value_query && digital_mode;
         if (port_value_query && digital_mode) begin
            port_value_rdata <= {pin3_sync, value_q[OUT1_BIT], value_q[OUT0_BIT]};
         end
      end
   end

   a_write_ignored: assert property (@(posedge clock) disable iff (!arst_n)
      !digital_mode |=> value_q == $past(value_q))
      else $error("value changed outside digital mode");

   a_write_stored: assert property (@(posedge clock) disable iff (!arst_n)
      port_value_command && digital_mode |=> value_q == $past(port_value_wdata))
      else $error("written value not stored");

   a_fixed_pins: assert property (@(posedge clock) disable iff (!arst_n)
      port_value_command && digital_mode |=> ##1
      pin1_out == $past(port_value_wdata[OUT0_BIT], 2) && pin2_out == $past(port_value_wdata[OUT1_BIT], 2))
      else $error("fixed pins do not follow value");

   a_shared_dir: assert property (@(posedge clock) disable iff (!arst_n)
      port_value_command && digital_mode && port_value_wdata >= 3'h4 |=> ##1 !pin3_oe)
      else $error("shared pin not released for input");

   a_shared_out: assert property (@(posedge clock) disable iff (!arst_n)
      port_value_command && digital_mode && port_value_wdata <= 3'h3 |=> ##1 pin3_oe && !pin3_out)
      else $error("shared pin not driven as output");

   a_query_data: assert property (@(posedge clock) disable iff (!arst_n)
      port_value_query && digital_mode |=> port_value_rvalid
      && port_value_rdata == {$past(pin3_sync), $past(value_q[1:0])})
      else $error("query data wrong");

   a_query_gated: assert property (@(posedge clock) disable iff (!arst_n)
      !(port_value_query && digital_mode) |=> !port_value_rvalid)
      else $error("answer without valid query");

   a_reset_low: assert property (@(posedge clock)
      $rose(arst_n) |-> value_q == VALUE_RESET && pin3_oe && !pin1_out && !pin2_out)
      else $error("reset state wrong");

   a_value_hold: assert property (@(posedge clock) disable iff (!arst_n)
      !port_value_command |=> value_q == $past(value_q))
      else $error("value changed without a command");

   a_value_from_write: assert property (@(posedge clock) disable iff (!arst_n)
      value_q != $past(value_q)
      |-> $past(port_value_command && digital_mode))
      else $error("value changed without accepted write");

   a_pin1_track: assert property (@(posedge clock) disable iff (!arst_n)
      1'h1 |=> pin1_out == $past(value_q[OUT0_BIT]))
      else $error("first fixed pin does not follow bit 0");

   a_pin2_track: assert property (@(posedge clock) disable iff (!arst_n)
      1'h1 |=> pin2_out == $past(value_q[OUT1_BIT]))
      else $error("second fixed pin does not follow bit 1");

   a_shared_track: assert property (@(posedge clock) disable iff (!arst_n)
      1'h1 |=> pin3_oe == !$past(value_q[SHARED_BIT]))
      else $error("shared pin direction does not follow bit 2");

   a_pins_stable: assert property (@(posedge clock) disable iff (!arst_n)
      $stable(value_q)
      |=> $stable(pin1_out) && $stable(pin2_out) && $stable(pin3_oe))
      else $error("pins moved while value held");

   a_input_mode: assert property (@(posedge clock) disable iff (!arst_n)
      value_q >= 3'h4 |=> !pin3_oe)
      else $error("values 4 to 7 do not release shared pin");

   a_output_mode: assert property (@(posedge clock) disable iff (!arst_n)
      value_q <= 3'h3 |=> pin3_oe && !pin3_out)
      else $error("values 0 to 3 do not drive shared pin");

   a_mode_pins_hold: assert property (@(posedge clock) disable iff (!arst_n)
      !digital_mode ##1 !digital_mode
      |=> $stable(pin1_out) && $stable(pin2_out) && $stable(pin3_oe))
      else $error("pins moved outside digital mode");

   a_mode_read_idle: assert property (@(posedge clock) disable iff (!arst_n)
      !digital_mode |=> $stable(port_value_rdata))
      else $error("read data moved outside digital mode");

   a_mode_no_answer: assert property (@(posedge clock) disable iff (!arst_n)
      !digital_mode |=> !port_value_rvalid)
      else $error("answer given outside digital mode");

   a_rdata_hold: assert property (@(posedge clock) disable iff (!arst_n)
      !(port_value_query && digital_mode) |=> $stable(port_value_rdata))
      else $error("read data moved without a query");

   a_query_pin: assert property (@(posedge clock) disable iff (!arst_n)
      port_value_query && digital_mode && $past(arst_n, 2)
      |=> port_value_rdata[SHARED_BIT] == $past(pin3_in, 3))
      else $error("read bit 2 is not the sampled pin level");

   a_sync_delay: assert property (@(posedge clock) disable iff (!arst_n)
      $past(arst_n, 2) |-> pin3_sync == $past(pin3_in, 2))
      else $error("shared pin sample latency wrong");

   a_sync_cleared: assert property (@(posedge clock)
      $rose(arst_n) |-> !pin3_sync)
      else $error("pin sample not cleared by reset");

   a_reset_answer: assert property (@(posedge clock)
      $rose(arst_n)
      |-> port_value_rdata == VALUE_RESET && !port_value_rvalid)
      else $error("read answer not cleared by reset");

   a_reset_shared: assert property (@(posedge clock)
      $rose(arst_n) |-> !pin3_out)
      else $error("shared pin not low after reset");

   a_chart_row0: assert property (@(posedge clock) disable iff (!arst_n)
      port_value_command && digital_mode && port_value_wdata == 3'h0
      |=> ##1 !pin1_out && !pin2_out && pin3_oe)
      else $error("chart row 0 not applied");

   a_chart_row1: assert property (@(posedge clock) disable iff (!arst_n)
      port_value_command && digital_mode && port_value_wdata == 3'h1
      |=> ##1 pin1_out && !pin2_out && pin3_oe)
      else $error("chart row 1 not applied");

   a_chart_row2: assert property (@(posedge clock) disable iff (!arst_n)
      port_value_command && digital_mode && port_value_wdata == 3'h2
      |=> ##1 !pin1_out && pin2_out && pin3_oe)
      else $error("chart row 2 not applied");

   a_chart_row3: assert property (@(posedge clock) disable iff (!arst_n)
      port_value_command && digital_mode && port_value_wdata == 3'h3
      |=> ##1 pin1_out && pin2_out && pin3_oe)
      else $error("chart row 3 not applied");

   a_chart_row4: assert property (@(posedge clock) disable iff (!arst_n)
      port_value_command && digital_mode && port_value_wdata == 3'h4
      |=> ##1 !pin1_out && !pin2_out && !pin3_oe)
      else $error("chart row 4 not applied");

   a_chart_row5: assert property (@(posedge clock) disable iff (!arst_n)
      port_value_command && digital_mode && port_value_wdata == 3'h5
      |=> ##1 pin1_out && !pin2_out && !pin3_oe)
      else $error("chart row 5 not applied");

   a_chart_row6: assert property (@(posedge clock) disable iff (!arst_n)
      port_value_command && digital_mode && port_value_wdata == 3'h6
      |=> ##1 !pin1_out && pin2_out && !pin3_oe)
      else $error("chart row 6 not applied");

   a_chart_row7: assert property (@(posedge clock) disable iff (!arst_n)
      port_value_command && digital_mode && port_value_wdata == 3'h7
      |=> ##1 pin1_out && pin2_out && !pin3_oe)
      else $error("chart row 7 not applied");
endmodule
`default_nettype wire

//--- tbio_equip.sv
// equipment wired to the shared pin
`timescale 1ns/1ps
`default_nettype none
module tbio_equip (
   // shared pin
   input  wire logic pin3_out,
   input  wire logic pin3_oe,
   input  wire logic drive_lvl,
   output logic      pin3_in
);
   assign pin3_in = pin3_oe ? pin3_out : drive_lvl;
endmodule
`default_nettype wire

//--- tb_tbio_port.sv
// self-checking bench for the three-bit port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; $display("[FAIL] %0t mismatch", $time); end end
module tb_tbio_port;
   logic       clock = 0, arst_n = 0, mode = 1, cmd = 0, qry = 0, lvl = 0;
   logic [2:0] wd = 3'h0, rdat;
   logic       rv, p1, p2, p3i, p3o, oe;
   int         failures = 0, compares = 0;
   tbio_port i_tbio_port (.clock(clock), .arst_n(arst_n), .digital_mode(mode),
      .port_value_command(cmd), .port_value_wdata(wd), .port_value_query(qry),
      .port_value_rdata(rdat), .port_value_rvalid(rv), .pin1_out(p1),
      .pin2_out(p2), .pin3_in(p3i), .pin3_out(p3o), .pin3_oe(oe));
   tbio_equip i_tbio_equip (.pin3_out(p3o), .pin3_oe(oe), .drive_lvl(lvl), .pin3_in(p3i));
   initial forever #2.5 clock = ~clock;
   task automatic wr(input logic [2:0] v);
      @(posedge clock);
      #1 cmd = 1;
      wd = v;
      @(posedge clock);
      #1 cmd = 0;
      repeat (3) @(posedge clock);
      #1;
   endtask
   task automatic rd(output logic [2:0] r, output logic v);
      @(posedge clock);
      #1 qry = 1;
      @(posedge clock);
      #1 qry = 0;
      v = rv;
      r = rdat;
   endtask
   task automatic wrap_up;
      $display("failures=%0d compares=%0d", failures, compares);
      if (failures == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      #2000;
      failures++;
      wrap_up;
   end
   initial begin
      logic [2:0] r;
      logic       v;
      repeat (10) @(posedge clock);
      #1 arst_n = 1;
      `CHK({p1, p2, p3o, oe}, 4'h1)
      rd(r, v);
      `CHK({v, r}, 4'h8)
      for (int i = 0; i < 8; i++) begin
         lvl = i[0];
         wr(i[2:0]);
         `CHK({oe, p2, p1}, {~i[2], i[1:0]})
         `CHK(p3o, 1'h0)
         rd(r, v);
         `CHK({v, r}, {1'h1, i[2] & i[0], i[1:0]})
      end
      mode = 0;
      wr(3'h0);
      `CHK({oe, p2, p1}, 3'h3)
      rd(r, v);
      `CHK(v, 1'h0)
      `CHK(r, 3'h7)
      mode = 1;
      arst_n = 0;
      repeat (2) @(posedge clock);
      #1 arst_n = 1;
      `CHK({p1, p2, p3o, oe}, 4'h1)
      rd(r, v);
      `CHK({v, r}, 4'h8)
      wr(3'h6);
      `CHK({oe, p2, p1}, 3'h2)
      wrap_up;
   end
endmodule
`default_nettype wire
